/* tupa_pkg.sv */
// shared constants and types for the timing unit port assignment block
`default_nettype none
package tupa_pkg;
	localparam int          NUM_UNITS     = 4;
	localparam int          UNIT_W        = 2;
	localparam int          CNT_W         = 34;
	localparam logic [33:0] CNT_MAX       = 34'h2_540B_E3FF;
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          MS_NS         = 1000000;
	localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int          MS_W          = 15;
	localparam logic [7:0]  ASC_LF        = 8'h0A;
	localparam logic [7:0]  ASC_SLASH     = 8'h2F;
	localparam logic [7:0]  ASC_EQ        = 8'h3D;
	localparam logic [7:0]  ASC_ZERO      = 8'h30;
	localparam logic [7:0]  ASC_ONE       = 8'h31;
	localparam logic [7:0]  ASC_FOUR      = 8'h34;
	localparam logic [7:0]  ASC_NINE      = 8'h39;
	localparam logic [7:0]  ASC_UP_A      = 8'h41;
	localparam logic [7:0]  ASC_UP_Z      = 8'h5A;
	localparam logic [7:0]  ASC_LOW_A     = 8'h61;
	localparam logic [7:0]  ASC_LOW_Z     = 8'h7A;
	localparam logic [7:0]  ASC_B         = 8'h42;
	localparam logic [7:0]  ASC_E         = 8'h45;
	localparam logic [7:0]  ASC_H         = 8'h48;
	localparam logic [7:0]  ASC_I         = 8'h49;
	localparam logic [7:0]  ASC_O         = 8'h4F;
	localparam logic [7:0]  ASC_U         = 8'h55;

	typedef enum logic [1:0]
	{
		MODE_NONE = 2'b00,
		MODE_IN   = 2'b01,
		MODE_OUT  = 2'b10
	} tupa_mode_t;

	localparam tupa_mode_t  DEF_MODE_U1 = MODE_OUT;
	localparam tupa_mode_t  DEF_MODE_U2 = MODE_IN;
	localparam logic [1:0]  DEF_PORT    = 2'h0;

	typedef enum logic [2:0]
	{
		PS_IDLE = 3'b000,
		PS_UNUM = 3'b001,
		PS_EQ   = 3'b010,
		PS_SEL  = 3'b011,
		PS_PNUM = 3'b100,
		PS_DONE = 3'b101,
		PS_SKIP = 3'b110
	} tupa_pstate_t;
endpackage : tupa_pkg
`default_nettype wire

/* tupa_link_if.sv */
// character link between host and timing unit device
`timescale 1ns/100ps
`default_nettype none
interface tupa_link_if;
	logic       chValid;
	logic [7:0] chData;
	logic       rspValid;
	logic [7:0] rspData;

	modport dev
	(
		input  chValid,
		input  chData,
		output rspValid,
		output rspData
	);

	modport host
	(
		output chValid,
		output chData,
		input  rspValid,
		input  rspData
	);
endinterface : tupa_link_if
`default_nettype wire

/* tupa_device.sv */
// device end: instruction parser, unit port assignment and ms counters
//
// Summary of operation
// R1 - four independent timing/counting units
// R2 - each unit: counting, interrupt or unassigned
// R3 - counter spans zero to 9 999 999 999
// R4 - output unit interrupts and pulses its line
// R5 - output syntax: U digit = [O digit]
// R6 - only digits 1-4 accepted, else error
// R7 - skip non-digits, first digit only used
// R8 - host assigns output before match/delay/period
// R9 - init: unit1 to output1, unit2 to input1
// R10 - lower-case characters are ignored
// R11 - host halts unit before output assignment
// R12 - new output assignment releases old port
// R13 - taken output port: error, nothing changes
// R14 - no port given: unit unassigned, port freed
// R15 - input syntax: U digit = [I digit]
// R16 - host assigns input before value instructions
// R17 - new input assignment releases old port
// R18 - taken input port: error, not executed
// R19 - host halts unit before input assignment
// R20 - fitted lines gate millisecond counting
// R21 - no lines fitted: count every millisecond
// R22 - line feed or slash ends an instruction
// R23 - error latched until error request reads it
`timescale 1ns/100ps
`default_nettype none
module tupa_device
	import tupa_pkg::*;
#(
	parameter int MS_CYC = tupa_pkg::MS_CYCLES
)
(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	tupa_link_if.dev                      link,
	input  wire logic [3:0]               externalCountGateLines,
	input  wire logic                     linesFitted,
	input  wire logic [3:0]               unitFire,
	output logic      [3:0]               externalPulseLines,
	output logic                          irq,
	output logic                          errFlag,
	output tupa_pkg::tupa_mode_t [3:0]    unitMode,
	output logic      [3:0][1:0]          unitPort,
	output logic      [3:0][33:0]         unitCount
);
	import tupa_pkg::*;

	typedef struct packed
	{
		tupa_pstate_t              st;
		logic [1:0]                unit;
		logic                      isOut;
		logic [1:0]                port;
		tupa_mode_t [3:0]          mode;
		logic [3:0][1:0]           prt;
		logic [3:0][CNT_W-1:0]     cnt;
		logic [MS_W-1:0]           msCnt;
		logic                      fitted;
		logic                      err;
		logic                      rspValid;
		logic [7:0]                rspData;
		logic [3:0]                pulse;
		logic                      irq;
	} tupa_dev_t;

	localparam tupa_mode_t [3:0] INIT_MODE = '{MODE_NONE, MODE_NONE, DEF_MODE_U2, DEF_MODE_U1};
	localparam logic [3:0][1:0]  INIT_PORT = {4{DEF_PORT}};
	localparam logic [MS_W-1:0]  MS_LAST   = MS_W'(MS_CYC - 1);

	localparam tupa_dev_t RST_VAL = '{
		st:       PS_IDLE,
		unit:     2'h0,
		isOut:    1'b0,
		port:     2'h0,
		mode:     INIT_MODE,
		prt:      INIT_PORT,
		cnt:      '0,
		msCnt:    '0,
		fitted:   1'b0,
		err:      1'b0,
		rspValid: 1'b0,
		rspData:  8'h00,
		pulse:    4'h0,
		irq:      1'b0
	};

	tupa_dev_t s_q;
	tupa_dev_t s_d;

	logic [7:0] ch;
	logic       isDig;
	logic       isValid;
	logic       isLow;
	logic       isUp;
	logic       isDelim;
	logic       tick;
	logic       clash;
	tupa_mode_t newMode;

	always_comb
	begin
		s_d      = s_q;
		ch       = link.chData;
		isDig    = (ch >= ASC_ZERO) && (ch <= ASC_NINE);
		isValid  = (ch >= ASC_ONE) && (ch <= ASC_FOUR); // R6
		isLow    = (ch >= ASC_LOW_A) && (ch <= ASC_LOW_Z);
		isUp     = (ch >= ASC_UP_A) && (ch <= ASC_UP_Z);
		isDelim  = (ch == ASC_LF) || (ch == ASC_SLASH); // R22
		tick     = (s_q.msCnt == MS_LAST);
		clash    = 1'b0;
		newMode  = s_q.isOut ? MODE_OUT : MODE_IN;
		s_d.rspValid = 1'b0;
		s_d.pulse    = 4'h0;
		s_d.irq      = 1'b0;
		s_d.fitted   = linesFitted;

		// ms timebase shared by all counting units
		s_d.msCnt = tick ? '0 : MS_W'(s_q.msCnt + 1'b1);
		for (int k = 0; k < NUM_UNITS; k++) // R1
		begin
			if (s_q.mode[k] == MODE_IN && tick &&
				(!s_q.fitted || externalCountGateLines[s_q.prt[k]])) // R20 R21
			begin
				s_d.cnt[k] = (s_q.cnt[k] == CNT_MAX) ? '0 : CNT_W'(s_q.cnt[k] + 1'b1); // R3
			end
			if (s_q.mode[k] == MODE_OUT && unitFire[k]) // R4
			begin
				s_d.pulse[s_q.prt[k]] = 1'b1;
				s_d.irq               = 1'b1;
			end
		end

		// port taken by some other unit in the requested direction
		for (int k = 0; k < NUM_UNITS; k++)
		begin
			if (2'(k) != s_q.unit && s_q.mode[k] == newMode && s_q.prt[k] == s_q.port)
			begin
				clash = 1'b1;
			end
		end

		if (link.chValid && !isLow) // R10
		begin
			unique case (s_q.st)
				PS_IDLE:
				begin
					if (ch == ASC_U)
					begin
						s_d.st = PS_UNUM;
					end
					else if (ch == ASC_B)
					begin
						s_d.mode = INIT_MODE; // R9
						s_d.prt  = INIT_PORT;
						s_d.st   = PS_SKIP;
					end
					else if (ch == ASC_E)
					begin
						s_d.rspValid = 1'b1; // R23
						s_d.rspData  = ASC_ZERO | {7'h00, s_q.err};
						s_d.err      = 1'b0;
					end
					else if (!isDelim)
					begin
						s_d.st = PS_SKIP;
					end
				end
				PS_UNUM:
				begin
					if (isDelim)
					begin
						s_d.err = 1'b1;
						s_d.st  = PS_IDLE;
					end
					else if (isDig) // R7
					begin
						s_d.unit = 2'(ch[1:0] - 2'h1);
						s_d.err  = s_q.err | !isValid; // R6
						s_d.st   = isValid ? PS_EQ : PS_SKIP;
					end
				end
				PS_EQ:
				begin
					// extra digits and spaces fall through; other upper-case letters are other instructions
					if (ch == ASC_EQ) // R5 R15
					begin
						s_d.st = PS_SEL;
					end
					else if (isDelim)
					begin
						s_d.st = PS_IDLE;
					end
					else if (isUp)
					begin
						s_d.st = PS_SKIP;
					end
				end
				PS_SEL:
				begin
					if (isDelim)
					begin
						s_d.mode[s_q.unit] = MODE_NONE; // R14
						s_d.st             = PS_IDLE;
					end
					else if (ch == ASC_O || ch == ASC_I) // R5 R15
					begin
						s_d.isOut = (ch == ASC_O);
						s_d.st    = PS_PNUM;
					end
				end
				PS_PNUM:
				begin
					if (isDelim)
					begin
						s_d.err = 1'b1;
						s_d.st  = PS_IDLE;
					end
					else if (isDig) // R7
					begin
						s_d.port = 2'(ch[1:0] - 2'h1);
						s_d.err  = s_q.err | !isValid; // R6
						s_d.st   = isValid ? PS_DONE : PS_SKIP;
					end
				end
				PS_DONE:
				begin
					if (isDelim)
					begin
						if (clash)
						begin
							s_d.err = 1'b1; // R13 R18
						end
						else
						begin
							s_d.mode[s_q.unit] = newMode; // R2 R12 R17
							s_d.prt[s_q.unit]  = s_q.port;
						end
						s_d.st = PS_IDLE;
					end
				end
				PS_SKIP:
				begin
					if (isDelim)
					begin
						s_d.st = PS_IDLE;
					end
				end
				default:
				begin
					s_d.st = PS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= RST_VAL; // R9
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign link.rspValid      = s_q.rspValid;
	assign link.rspData       = s_q.rspData;
	assign externalPulseLines = s_q.pulse;
	assign irq                = s_q.irq;
	assign errFlag            = s_q.err;
	assign unitMode           = s_q.mode;
	assign unitPort           = s_q.prt;
	assign unitCount          = s_q.cnt;
endmodule : tupa_device
`default_nettype wire

/* tupa_host.sv */
// host end: turns assignment commands into halt plus define strings
`timescale 1ns/100ps
`default_nettype none
module tupa_host
	import tupa_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	tupa_link_if.host       link,
	input  wire logic       cmdValid,
	input  wire logic [1:0] cmdUnit,
	input  wire logic       cmdOut,
	input  wire logic [2:0] cmdPort,
	input  wire logic       errReq,
	output logic            cmdReady,
	output logic            errValid,
	output logic            errBit
);
	import tupa_pkg::*;

	typedef struct packed
	{
		logic       busy;
		logic [3:0] idx;
		logic [1:0] unit;
		logic       isOut;
		logic [2:0] port;
		logic       chValid;
		logic [7:0] chData;
		logic       errValid;
		logic       errBit;
	} tupa_host_t;

	localparam logic [3:0] LAST_IDX = 4'h9;

	tupa_host_t s_q;
	tupa_host_t s_d;
	logic [7:0] uDig;
	logic [7:0] pDig;
	logic [7:0] nxt;

	always_comb
	begin
		s_d          = s_q;
		uDig         = ASC_ONE + {6'h00, s_q.unit};
		pDig         = ASC_ZERO + {5'h00, s_q.port};
		s_d.chValid  = 1'b0;
		s_d.errValid = link.rspValid;
		if (link.rspValid)
		begin
			s_d.errBit = link.rspData[0];
		end
		// halt the unit first, then define it; assignments and E error requests are the only strings sent
		unique case (s_q.idx) // R8 R11 R16 R19
			4'h0:    nxt = ASC_U;
			4'h1:    nxt = uDig;
			4'h2:    nxt = ASC_H;
			4'h3:    nxt = ASC_LF;
			4'h4:    nxt = ASC_U;
			4'h5:    nxt = uDig;
			4'h6:    nxt = ASC_EQ; // R5 R15
			4'h7:    nxt = (s_q.port == 3'h0) ? ASC_LF : (s_q.isOut ? ASC_O : ASC_I); // R14
			4'h8:    nxt = pDig;
			default: nxt = ASC_LF; // R22
		endcase
		if (s_q.busy)
		begin
			s_d.chValid = 1'b1;
			s_d.chData  = nxt;
			s_d.idx     = 4'(s_q.idx + 1'b1);
			if (s_q.idx == LAST_IDX || (s_q.idx == 4'h7 && s_q.port == 3'h0))
			begin
				s_d.busy = 1'b0;
				s_d.idx  = 4'h0;
			end
		end
		else if (cmdValid)
		begin
			s_d.busy  = 1'b1;
			s_d.unit  = cmdUnit;
			s_d.isOut = cmdOut;
			s_d.port  = cmdPort;
		end
		else if (errReq)
		begin
			s_d.chValid = 1'b1; // R23
			s_d.chData  = ASC_E;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign link.chValid = s_q.chValid;
	assign link.chData  = s_q.chData;
	assign cmdReady     = !s_q.busy;
	assign errValid     = s_q.errValid;
	assign errBit       = s_q.errBit;
endmodule : tupa_host
`default_nettype wire

/* tupa_link_chk.sv */
// link checker: character protocol between host and device ends
`timescale 1ns/100ps
`default_nettype none
module tupa_link_chk
	import tupa_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       chValid,
	input  wire logic [7:0] chData,
	input  wire logic       rspValid,
	input  wire logic [7:0] rspData
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_errAns;
		chValid && chData == ASC_E |=> rspValid ##1 !rspValid;
	endproperty
	a_errAns: assert property (p_errAns) else $error("no single answer to E");
	property p_ansCause;
		rspValid |-> $past(chValid) && $past(chData) == ASC_E;
	endproperty
	a_ansCause: assert property (p_ansCause) else $error("answer without E");
	property p_ansCode;
		rspValid |-> rspData == ASC_ZERO || rspData == ASC_ONE;
	endproperty
	a_ansCode: assert property (p_ansCode) else $error("bad answer code");
	property p_ansHold;
		!rspValid |-> $stable(rspData);
	endproperty
	a_ansHold: assert property (p_ansHold) else $error("answer data moved");
	property p_unitDig;
		chValid && chData == ASC_U |=> chValid && chData >= ASC_ONE && chData <= ASC_FOUR;
	endproperty
	a_unitDig: assert property (p_unitDig) else $error("unit digit bad");
	// a define must follow a halt sent four characters earlier
	property p_haltFirst;
		chValid && chData == ASC_EQ |-> $past(chValid, 4) && $past(chData, 4) == ASC_H;
	endproperty
	a_haltFirst: assert property (p_haltFirst) else $error("define not halted");
	property p_eqNext;
		chValid && chData == ASC_EQ |=> chValid
			&& (chData == ASC_O || chData == ASC_I || chData == ASC_LF);
	endproperty
	a_eqNext: assert property (p_eqNext) else $error("bad char after equals");
	property p_selNext;
		chValid && (chData == ASC_O || chData == ASC_I) |=> chValid && chData > ASC_ZERO
			&& chData <= ASC_NINE ##1 chValid && chData == ASC_LF;
	endproperty
	a_selNext: assert property (p_selNext) else $error("port field bad");
	property p_hNext;
		chValid && chData == ASC_H |=> chValid && chData == ASC_LF ##1 chValid && chData == ASC_U;
	endproperty
	a_hNext: assert property (p_hNext) else $error("halt not closed");
	c_errSet: cover property (rspValid && rspData == ASC_ONE);
	c_unassign: cover property (chValid && chData == ASC_EQ ##1 chValid && chData == ASC_LF);
	c_input: cover property (chValid && chData == ASC_I);
endmodule : tupa_link_chk
`default_nettype wire

/* tupa_test.sv */
// self-checking bench: host and device across the link, plus a raw-driven device
`timescale 1ns/100ps
`default_nettype none
module tupa_test;
	import tupa_pkg::*;
	localparam int MSC = 10;
	logic                  clk      = 1'b0;
	logic                  rst_n    = 1'b0;
	logic                  cmdValid = 1'b0;
	logic                  cmdOut   = 1'b0;
	logic                  errReq   = 1'b0;
	logic                  fitted   = 1'b1;
	logic [1:0]            cmdUnit  = 2'h0;
	logic [2:0]            cmdPort  = 3'h0;
	logic [3:0]            gate     = 4'h0;
	logic [3:0]            fire     = 4'h0;
	logic                  cmdReady;
	logic                  errValid;
	logic                  errBit;
	logic                  irq;
	logic                  errA;
	logic                  errB;
	logic [3:0]            pulse;
	tupa_mode_t [3:0]      modeA;
	tupa_mode_t [3:0]      modeB;
	logic [3:0][1:0]       portA;
	logic [3:0][1:0]       portB;
	logic [3:0][33:0]      cntA;
	logic [3:0][33:0]      base;
	int                    errors   = 0;
	int                    n_tests  = 0;
	string                 seen     = "";

	always #20 clk = ~clk;

	tupa_link_if linkA ();
	tupa_link_if linkB ();
	tupa_host tupa_host_i (.clk(clk), .rst_n(rst_n), .link(linkA), .cmdValid(cmdValid),
		.cmdUnit(cmdUnit), .cmdOut(cmdOut), .cmdPort(cmdPort), .errReq(errReq),
		.cmdReady(cmdReady), .errValid(errValid), .errBit(errBit));
	tupa_device #(.MS_CYC(MSC)) tupa_device_i (.clk(clk), .rst_n(rst_n), .link(linkA),
		.externalCountGateLines(gate), .linesFitted(fitted), .unitFire(fire),
		.externalPulseLines(pulse), .irq(irq), .errFlag(errA), .unitMode(modeA),
		.unitPort(portA), .unitCount(cntA));
	// second device takes raw strings straight from the bench
	tupa_device #(.MS_CYC(MSC)) tupa_device_rx_i (.clk(clk), .rst_n(rst_n), .link(linkB),
		.externalCountGateLines(4'h0), .linesFitted(1'b0), .unitFire(4'h0),
		.externalPulseLines(), .irq(), .errFlag(errB), .unitMode(modeB),
		.unitPort(portB), .unitCount());
	tupa_link_chk tupa_link_chk_i (.clk(clk), .rst_n(rst_n), .chValid(linkA.chValid),
		.chData(linkA.chData), .rspValid(linkA.rspValid), .rspData(linkA.rspData));

	// sampled mid-cycle: chValid is a flop launched on the rising edge
	always @(negedge clk)
		if (linkA.chValid)
			seen = {seen, $sformatf("%c", linkA.chData)};

	task give_verdict;
		$display("errors=%0d tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task chkV(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask : chkV

	task chkS(input string nm, input string e, input string g);
		n_tests++;
		if (g != e)
		begin
			errors++;
			$display("[ERR] %s exp %s got %s", nm, e, g);
		end
	endtask : chkS

	task chkU(input logic b, input logic [1:0] u, input tupa_mode_t m, input logic [1:0] p);
		chkV("mode", 34'(m), 34'(b ? modeB[u] : modeA[u]));
		if (m != MODE_NONE)
			chkV("port", 34'(p), 34'(b ? portB[u] : portA[u]));
	endtask : chkU

	// bounded wait; running out ends the run as a failure
	task automatic waitHi(ref logic s);
		int i;
		for (i = 0; i < 40 && s !== 1'b1; i++)
			@(negedge clk);
		if (i == 40)
		begin
			errors++;
			give_verdict();
		end
	endtask : waitHi

	task cmd(input logic [1:0] u, input logic o, input logic [2:0] p);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdUnit  <= u;
		cmdOut   <= o;
		cmdPort  <= p;
		@(posedge clk);
		cmdValid <= 1'b0;
		repeat (2) @(negedge clk);
		waitHi(cmdReady);
		repeat (3) @(negedge clk);
	endtask : cmd

	task errRd(input logic e);
		@(posedge clk);
		errReq <= 1'b1;
		@(posedge clk);
		errReq <= 1'b0;
		waitHi(errValid);
		chkV("errBit", 34'(e), 34'(errBit));
	endtask : errRd

	task send(input string s);
		foreach (s[i])
		begin
			@(posedge clk);
			linkB.chValid <= 1'b1;
			linkB.chData  <= s[i];
		end
		@(posedge clk);
		linkB.chValid <= 1'b0;
		linkB.chData  <= ~linkB.chData;
		repeat (2) @(negedge clk);
	endtask : send

	initial
	begin
		linkB.chValid = 1'b0;
		linkB.chData  = 8'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chkU(1'h0, 2'h0, MODE_OUT, 2'h0);
		chkU(1'h0, 2'h1, MODE_IN, 2'h0);
		chkU(1'h0, 2'h2, MODE_NONE, 2'h0);
		errRd(1'h0);
		seen = "";
		cmd(2'h0, 1'h1, 3'h3);
		chkS("link", "U1H\nU1=O3\n", seen);
		chkU(1'h0, 2'h0, MODE_OUT, 2'h2);
		cmd(2'h0, 1'h1, 3'h4);
		chkU(1'h0, 2'h0, MODE_OUT, 2'h3);
		cmd(2'h1, 1'h1, 3'h4);
		chkU(1'h0, 2'h1, MODE_IN, 2'h0);
		chkV("errA", 34'h1, 34'(errA));
		errRd(1'h1);
		chkV("errA", 34'h0, 34'(errA));
		errRd(1'h0);
		cmd(2'h0, 1'h1, 3'h0);
		chkU(1'h0, 2'h0, MODE_NONE, 2'h0);
		cmd(2'h1, 1'h1, 3'h4);
		chkU(1'h0, 2'h1, MODE_OUT, 2'h3);
		cmd(2'h2, 1'h0, 3'h2);
		cmd(2'h3, 1'h0, 3'h2);
		chkU(1'h0, 2'h3, MODE_NONE, 2'h0);
		errRd(1'h1);
		cmd(2'h2, 1'h0, 3'h3);
		cmd(2'h3, 1'h0, 3'h2);
		chkU(1'h0, 2'h3, MODE_IN, 2'h1);
		chkU(1'h0, 2'h2, MODE_IN, 2'h2);
		cmd(2'h3, 1'h1, 3'h5);
		errRd(1'h1);
		chkU(1'h0, 2'h3, MODE_IN, 2'h1);
		// exactly ten ticks fall in any hundred-cycle span
		@(posedge clk);
		gate <= 4'h4;
		repeat (3) @(negedge clk);
		base = cntA;
		repeat (10 * MSC) @(negedge clk);
		chkV("cnt3", base[2] + 34'hA, cntA[2]);
		chkV("cnt4", base[3], cntA[3]);
		@(posedge clk);
		fitted <= 1'b0;
		repeat (3) @(negedge clk);
		base = cntA;
		repeat (10 * MSC) @(negedge clk);
		chkV("cnt4", base[3] + 34'hA, cntA[3]);
		@(posedge clk);
		fire <= 4'h3;
		@(posedge clk);
		fire <= 4'h0;
		@(negedge clk);
		chkV("pulse", 34'h8, 34'(pulse));
		chkV("irq", 34'h1, 34'(irq));
		send("U1=\n");
		chkU(1'h1, 2'h0, MODE_NONE, 2'h0);
		send("Unit 3 = Output -39.7\n");
		chkU(1'h1, 2'h2, MODE_OUT, 2'h2);
		send("U4=I2/");
		chkU(1'h1, 2'h3, MODE_IN, 2'h1);
		send("B\n");
		chkU(1'h1, 2'h0, MODE_OUT, 2'h0);
		send("U0=O1/");
		chkV("errB", 34'h1, 34'(errB));
		send("E");
		chkV("rspB", 34'(ASC_ONE), 34'(linkB.rspData));
		chkV("errB", 34'h0, 34'(errB));
		send("U3=O/");
		chkV("errB", 34'h1, 34'(errB));
		chkU(1'h1, 2'h2, MODE_NONE, 2'h0);
		give_verdict();
	end
endmodule : tupa_test
`default_nettype wire
